// [wkt_defines.vh]
// Register map, field layout and reset values of the wake-up timer
`ifndef WKT_DEFINES_VH
`define WKT_DEFINES_VH

`define WKT_ADDR_RELOAD      32'hffff0340
`define WKT_ADDR_COUNT       32'hffff0344
`define WKT_ADDR_CONTROL     32'hffff0348
`define WKT_ADDR_CLEAR       32'hffff034c
`define WKT_ADDR_IRQ_STATUS  32'hffff0350
`define WKT_ADDR_IRQ_MASK    32'hffff0354

`define WKT_RELOAD_RESET     32'h00000000
`define WKT_COUNT_RESET      32'h0fffffff
`define WKT_CONTROL_RESET    16'h0000
`define WKT_CONTROL_WMASK    16'h07ff

`define WKT_CLKSEL_MSB       10
`define WKT_CLKSEL_LSB       9
`define WKT_DIR_BIT          8
`define WKT_EN_BIT           7
`define WKT_PERIODIC_BIT     6
`define WKT_FORMAT_MSB       5
`define WKT_FORMAT_LSB       4
`define WKT_SCALE_MSB        3
`define WKT_SCALE_LSB        0

`define WKT_SRC_LP_OSC       2'h0
`define WKT_SRC_CORE_DIV     2'h1
`define WKT_SRC_CRYSTAL      2'h2
`define WKT_SRC_FAST         2'h3

`define WKT_SCALE_DIV1       4'h0
`define WKT_SCALE_DIV16      4'h4
`define WKT_SCALE_DIV256     4'h8
`define WKT_SCALE_DIV32768   4'hf

`define WKT_FMT_BINARY       2'h0
`define WKT_FMT_TOD23        2'h2
`define WKT_FMT_TOD255       2'h3
`define WKT_TOD_HMAX23       8'h17
`define WKT_TOD_HMAX255      8'hff
`define WKT_TOD_CENT_MAX     8'h63
`define WKT_TOD_SECMIN_MAX   8'h3b

`define WKT_IRQ_TIMEOUT_BIT  0
`define WKT_IRQ_WIDTH        1

`endif

// [wkt_timer.v]
// Wake-up timer: 32-bit up/down counter with prescaler, time-of-day format and Wishbone registers
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "wkt_defines.vh"

module wkt_timer (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        lp_osc_clk,
  input  wire        core_div_clk,
  input  wire        external_crystal_input,
  input  wire        fast_osc_clk,
  output reg         irq
);

  // Prescale terminal count for each legal code; undefined codes fall back to /1
  function [14:0] wkt_scale_limit;
    input [3:0] code;
    begin
      case (code)
        `WKT_SCALE_DIV16:    wkt_scale_limit = 15'h000f;
        `WKT_SCALE_DIV256:   wkt_scale_limit = 15'h00ff;
        `WKT_SCALE_DIV32768: wkt_scale_limit = 15'h7fff;
        default:             wkt_scale_limit = 15'h0000;
      endcase
    end
  endfunction

  // Merge a write word into a register, one byte lane at a time
  function [31:0] wkt_lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  lanes;
    reg   [31:0] acc;
    integer      b;
    begin
      acc = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (lanes[b]) begin
          acc[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
      wkt_lane_merge = acc;
    end
  endfunction

  // One plain binary step; MSB is the wrap flag
  function [32:0] wkt_bin_step;
    input [31:0] v;
    input        up;
    begin
      if (up) begin
        wkt_bin_step = {v == 32'hffffffff, v + 32'h00000001};
      end else begin
        wkt_bin_step = {v == 32'h00000000, v - 32'h00000001};
      end
    end
  endfunction

  // One step of the packed hours:minutes:seconds:hundredths count; MSB is the wrap flag
  function [32:0] wkt_tod_step;
    input [31:0] v;
    input        up;
    input [7:0]  hmax;
    reg   [7:0]  h;
    reg   [7:0]  m;
    reg   [7:0]  s;
    reg   [7:0]  c;
    reg          cy;
    begin
      h  = v[31:24];
      m  = v[23:16];
      s  = v[15:8];
      c  = v[7:0];
      cy = 1'b0;
      if (up) begin
        if (c >= `WKT_TOD_CENT_MAX) begin
          c = 8'h00;
          if (s >= `WKT_TOD_SECMIN_MAX) begin
            s = 8'h00;
            if (m >= `WKT_TOD_SECMIN_MAX) begin
              m = 8'h00;
              if (h >= hmax) begin
                h  = 8'h00;
                cy = 1'b1;
              end else begin
                h = h + 8'h01;
              end
            end else begin
              m = m + 8'h01;
            end
          end else begin
            s = s + 8'h01;
          end
        end else begin
          c = c + 8'h01;
        end
      end else begin
        if (c == 8'h00) begin
          c = `WKT_TOD_CENT_MAX;
          if (s == 8'h00) begin
            s = `WKT_TOD_SECMIN_MAX;
            if (m == 8'h00) begin
              m = `WKT_TOD_SECMIN_MAX;
              if (h == 8'h00) begin
                h  = hmax;
                cy = 1'b1;
              end else begin
                h = h - 8'h01;
              end
            end else begin
              m = m - 8'h01;
            end
          end else begin
            s = s - 8'h01;
          end
        end else begin
          c = c - 8'h01;
        end
      end
      wkt_tod_step = {cy, h, m, s, c};
    end
  endfunction

  reg  [31:0] reload_value;
  reg  [31:0] current_count;
  reg  [15:0] timer_control;
  reg  [`WKT_IRQ_WIDTH-1:0] irq_status;
  reg  [`WKT_IRQ_WIDTH-1:0] irq_mask;
  reg  [14:0] pre_cnt;
  reg  [3:0]  src_meta;
  reg  [3:0]  src_sync;
  reg         src_prev;

  reg  [31:0] next_count;
  reg  [14:0] next_pre_cnt;
  reg         timeout;
  reg  [31:0] stepped;
  reg         wrapped;
  reg  [32:0] tod_res;
  reg  [31:0] rd_data;
  reg  [31:0] next_reload;
  reg  [15:0] next_control;
  reg  [31:0] ctl_merged;
  reg  [`WKT_IRQ_WIDTH-1:0] next_mask;
  reg  [`WKT_IRQ_WIDTH-1:0] next_status;
  reg  [31:0] next_dat;
  reg         next_ack;
  reg         next_irq;

  wire [1:0]  clock_source_select = timer_control[`WKT_CLKSEL_MSB:`WKT_CLKSEL_LSB];
  wire        count_direction     = timer_control[`WKT_DIR_BIT];
  wire        timer_enable        = timer_control[`WKT_EN_BIT];
  wire        periodic_select     = timer_control[`WKT_PERIODIC_BIT];
  wire [1:0]  count_format        = timer_control[`WKT_FORMAT_MSB:`WKT_FORMAT_LSB];
  wire [3:0]  prescale_select     = timer_control[`WKT_SCALE_MSB:`WKT_SCALE_LSB];

  wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr       = access & wb_we_i;

  // Full 32-bit compares; a partial decode would alias the neighbouring timers
  wire        hit_reload  = (wb_adr_i == `WKT_ADDR_RELOAD);
  wire        hit_control = (wb_adr_i == `WKT_ADDR_CONTROL);
  wire        hit_clear   = (wb_adr_i == `WKT_ADDR_CLEAR);
  wire        hit_status  = (wb_adr_i == `WKT_ADDR_IRQ_STATUS);
  wire        hit_mask    = (wb_adr_i == `WKT_ADDR_IRQ_MASK);
  wire        wr_clear    = wr & hit_clear;

  // Undefined prescale codes fall back to /1
  wire [14:0] pre_limit   = wkt_scale_limit(prescale_select);

  // Source pins are asynchronous; two stages before anything looks at them
  always @(posedge ref_clk) begin
    if (!nrst) begin
      src_meta <= 4'h0;
      src_sync <= 4'h0;
    end else begin
      src_meta <= {fast_osc_clk, external_crystal_input, core_div_clk, lp_osc_clk};
      src_sync <= src_meta;
    end
  end

  // Selected source, rising edge detect
  wire src_sel  = src_sync[clock_source_select];
  wire src_rise = src_sel & ~src_prev;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_sel;
    end
  end

  // Prescaler and counter step
  // ref_clk never stops with the core clock, so counting goes on while the core sleeps
  always @* begin
    next_pre_cnt = pre_cnt;
    next_count   = current_count;
    timeout      = 1'b0;
    stepped      = current_count;
    wrapped      = 1'b0;
    tod_res      = 33'h000000000;
    if (count_format == `WKT_FMT_TOD23) begin
      tod_res = wkt_tod_step(current_count, count_direction, `WKT_TOD_HMAX23);
    end else begin
      tod_res = wkt_tod_step(current_count, count_direction, `WKT_TOD_HMAX255);
    end
    if (count_format[1]) begin
      stepped = tod_res[31:0];
      wrapped = tod_res[32];
    end else begin
      {wrapped, stepped} = wkt_bin_step(current_count, count_direction);
    end

    if (!timer_enable) begin
      next_pre_cnt = 15'h0000;
    end else if (src_rise) begin
      if (pre_cnt >= pre_limit) begin
        next_pre_cnt = 15'h0000;
        timeout      = wrapped;
        if (wrapped && periodic_select) begin
          next_count = reload_value;
        end else begin
          next_count = stepped;
        end
      end else begin
        next_pre_cnt = pre_cnt + 15'h0001;
      end
    end
    // A clear write restarts the count from the reload value at once
    if (wr_clear) begin
      next_count   = reload_value;
      next_pre_cnt = 15'h0000;
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      pre_cnt       <= 15'h0000;
      current_count <= `WKT_COUNT_RESET;
    end else begin
      pre_cnt       <= next_pre_cnt;
      current_count <= next_count;
    end
  end

  // Next register values; writes land at the take edge, byte lanes honoured
  always @* begin
    next_reload  = reload_value;
    next_control = timer_control;
    next_mask    = irq_mask;
    next_status  = irq_status;
    ctl_merged   = wkt_lane_merge({16'h0000, timer_control}, wb_dat_i, wb_sel_i);

    if (wr && hit_reload) begin
      next_reload = wkt_lane_merge(reload_value, wb_dat_i, wb_sel_i);
    end

    // Reserved bits 15:11 never stored, so they always read back zero
    if (wr && hit_control) begin
      next_control = ctl_merged[15:0] & `WKT_CONTROL_WMASK;
    end

    if (wr && hit_mask && wb_sel_i[0]) begin
      next_mask = wb_dat_i[`WKT_IRQ_WIDTH-1:0];
    end

    // Set beats clear, so a timeout that lands with the clear is not lost
    if (wr_clear) begin
      next_status = {`WKT_IRQ_WIDTH{1'b0}};
    end else if (wr && hit_status && wb_sel_i[0]) begin
      next_status = irq_status & ~wb_dat_i[`WKT_IRQ_WIDTH-1:0];
    end
    if (timeout) begin
      next_status[`WKT_IRQ_TIMEOUT_BIT] = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      reload_value  <= `WKT_RELOAD_RESET;
      timer_control <= `WKT_CONTROL_RESET;
      irq_mask      <= {`WKT_IRQ_WIDTH{1'b0}};
      irq_status    <= {`WKT_IRQ_WIDTH{1'b0}};
    end else begin
      reload_value  <= next_reload;
      timer_control <= next_control;
      irq_mask      <= next_mask;
      irq_status    <= next_status;
    end
  end

  // Read mux; the clear register and unmapped addresses read zero
  always @* begin
    case (wb_adr_i)
      `WKT_ADDR_RELOAD: begin
        rd_data = reload_value;
      end
      `WKT_ADDR_COUNT: begin
        rd_data = current_count;
      end
      `WKT_ADDR_CONTROL: begin
        rd_data = {16'h0000, timer_control & `WKT_CONTROL_WMASK};
      end
      `WKT_ADDR_IRQ_STATUS: begin
        rd_data = {{(32-`WKT_IRQ_WIDTH){1'b0}}, irq_status};
      end
      `WKT_ADDR_IRQ_MASK: begin
        rd_data = {{(32-`WKT_IRQ_WIDTH){1'b0}}, irq_mask};
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  // One-cycle ack, every address answered so a stray access cannot hang the bus
  // Read data held between reads, so a slow master may still pick it up
  always @* begin
    next_ack = access;
    next_dat = wb_dat_o;
    if (access && !wb_we_i) begin
      next_dat = rd_data;
    end
    next_irq = |(irq_status & irq_mask);
  end

  // Every output leaves a flip-flop; irq trails the status by one cycle
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq      <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      irq      <= next_irq;
    end
  end

endmodule

// [wkt_chk_monitor.sv]
// Bus and interrupt assertions for the wake-up timer
`timescale 1ns/10ps
`include "wkt_defines.vh"
module wkt_chk (
  input logic        ref_clk,
  input logic        nrst,
  input logic [31:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0]  wb_sel_i,
  input logic        wb_we_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        lp_osc_clk,
  input logic        core_div_clk,
  input logic        external_crystal_input,
  input logic        fast_osc_clk,
  input logic        irq
);
  // Sources idle long enough that no timeout can still be in flight
  logic [2:0] quiet;
  wire        act = lp_osc_clk | core_div_clk | external_crystal_input | fast_osc_clk;
  wire        wr  = wb_ack_o & wb_we_i;
  wire        rd  = wb_ack_o & !wb_we_i;
  always @(posedge ref_clk)
    if (!nrst || act) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("no ack after take");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_clr_rd; rd && wb_adr_i == `WKT_ADDR_CLEAR |-> wb_dat_o == 32'h0; endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear register readable");
  property p_ctl_rsv; rd && wb_adr_i == `WKT_ADDR_CONTROL |-> wb_dat_o[31:11] == 21'h0; endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("reserved control bits set");
  property p_clr_irq; wr && wb_adr_i == `WKT_ADDR_CLEAR && quiet == 3'h7 |=> !irq; endproperty
  a_clr_irq: assert property (p_clr_irq) else $error("irq kept after clear");
  property p_mask; wr && wb_adr_i == `WKT_ADDR_IRQ_MASK && wb_sel_i[0] && !wb_dat_i[0] |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq asserted");
  property p_w1c;
    wr && wb_adr_i == `WKT_ADDR_IRQ_STATUS && wb_sel_i[0] && wb_dat_i[0] && quiet == 3'h7 |=> !irq;
  endproperty
  a_w1c: assert property (p_w1c) else $error("irq kept after status clear");
  property p_irq_hold; quiet == 3'h7 && !$past(wb_ack_o) |-> $stable(irq); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq moved without cause");
endmodule

bind wkt_timer wkt_chk u_chk (.*);

// [tb_top.sv]
// Register-level bench for the wake-up timer
`timescale 1ns/10ps
`include "wkt_defines.vh"
module tb_top;
  logic        ref_clk  = 1'b0;
  logic        nrst     = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_we_i  = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [3:0]  src      = 4'h0;
  logic [31:0] q;
  logic [3:0]  sc [4]   = '{4'h0, 4'h4, 4'h8, 4'hf};
  int          dv [4]   = '{1, 16, 256, 32768};
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         irq;
  integer      num_errors = 0;
  integer      n_tests    = 0;
  integer      i;
  always #20 ref_clk = ~ref_clk;
  wkt_timer u_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lp_osc_clk(src[0]), .core_div_clk(src[1]),
    .external_crystal_input(src[2]), .fast_osc_clk(src[3]), .irq(irq));
  task end_of_test;
    begin
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task xfer(input we, input [31:0] a, input [31:0] d);
    integer k;
    begin
      k = 0;
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
        @(posedge ref_clk);
        k = k + 1;
      end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (wb_ack_o !== 1'b1) begin
        num_errors = num_errors + 1;
        end_of_test;
      end
    end
  endtask
  task rc(input [31:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  // One source cycle is one high and one low ref_clk period
  task pulse(input [1:0] s, input integer n);
    begin
      repeat (n) begin
        @(posedge ref_clk);
        src[s] <= 1'b1;
        @(posedge ref_clk);
        src[s] <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
    end
  endtask
  function [31:0] cw(input [1:0] s, input up, input per, input [1:0] f, input [3:0] p);
    cw = {21'h0, s, up, 1'b1, per, f, p};
  endfunction
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    rc(`WKT_ADDR_RELOAD, 32'h0);
    rc(`WKT_ADDR_COUNT, 32'h0fffffff);
    rc(`WKT_ADDR_CONTROL, 32'h0);
    rc(`WKT_ADDR_CLEAR, 32'h0);
    xfer(1'b1, `WKT_ADDR_CONTROL, 32'hffffff7f);
    rc(`WKT_ADDR_CONTROL, 32'h0000077f);
    xfer(1'b1, `WKT_ADDR_COUNT, 32'h12345678);
    pulse(2'h3, 2);
    rc(`WKT_ADDR_COUNT, 32'h0fffffff);
    xfer(1'b1, `WKT_ADDR_RELOAD, 32'h2);
    xfer(1'b1, `WKT_ADDR_CLEAR, 32'h0);
    rc(`WKT_ADDR_COUNT, 32'h2);
    xfer(1'b1, `WKT_ADDR_IRQ_MASK, 32'h1);
    xfer(1'b1, `WKT_ADDR_CONTROL, cw(2'h0, 1'b0, 1'b0, 2'h0, 4'h0));
    pulse(2'h0, 2);
    rc(`WKT_ADDR_COUNT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    pulse(2'h0, 1);
    rc(`WKT_ADDR_COUNT, 32'hffffffff);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, `WKT_ADDR_CLEAR, 32'h5a);
    rc(`WKT_ADDR_COUNT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `WKT_ADDR_IRQ_MASK, 32'h0);
    pulse(2'h0, 3);
    chk({31'h0, irq}, 32'h0);
    rc(`WKT_ADDR_IRQ_STATUS, 32'h1);
    xfer(1'b1, `WKT_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, `WKT_ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `WKT_ADDR_RELOAD, 32'hfffffffe);
    xfer(1'b1, `WKT_ADDR_CLEAR, 32'h0);
    xfer(1'b1, `WKT_ADDR_CONTROL, cw(2'h3, 1'b1, 1'b1, 2'h0, 4'h0));
    pulse(2'h3, 1);
    rc(`WKT_ADDR_COUNT, 32'hffffffff);
    pulse(2'h3, 1);
    rc(`WKT_ADDR_COUNT, 32'hfffffffe);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, `WKT_ADDR_CONTROL, cw(i[1:0], 1'b0, 1'b0, 2'h0, 4'h0));
      xfer(1'b1, `WKT_ADDR_CLEAR, 32'h0);
      pulse(i[1:0] + 2'h1, 1);
      pulse(i[1:0], 1);
      rc(`WKT_ADDR_COUNT, 32'hfffffffd);
    end
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, `WKT_ADDR_CONTROL, cw(2'h3, 1'b0, 1'b0, 2'h0, sc[i]));
      xfer(1'b1, `WKT_ADDR_CLEAR, 32'h0);
      pulse(2'h3, dv[i] - 1);
      rc(`WKT_ADDR_COUNT, 32'hfffffffe);
      pulse(2'h3, 1);
      rc(`WKT_ADDR_COUNT, 32'hfffffffd);
    end
    xfer(1'b1, `WKT_ADDR_RELOAD, 32'h0);
    for (i = 2; i < 4; i = i + 1) begin
      xfer(1'b1, `WKT_ADDR_CONTROL, cw(2'h0, 1'b0, 1'b0, i[1:0], 4'h8));
      xfer(1'b1, `WKT_ADDR_CLEAR, 32'h0);
      pulse(2'h0, 256);
      rc(`WKT_ADDR_COUNT, (i == 2) ? 32'h173b3b63 : 32'hff3b3b63);
    end
    xfer(1'b1, `WKT_ADDR_RELOAD, 32'h00003b63);
    xfer(1'b1, `WKT_ADDR_CONTROL, cw(2'h0, 1'b1, 1'b0, 2'h2, 4'h8));
    xfer(1'b1, `WKT_ADDR_CLEAR, 32'h0);
    pulse(2'h0, 256);
    rc(`WKT_ADDR_COUNT, 32'h00010000);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    rc(`WKT_ADDR_RELOAD, 32'h0);
    rc(`WKT_ADDR_COUNT, 32'h0fffffff);
    rc(`WKT_ADDR_CONTROL, 32'h0);
    end_of_test;
  end
endmodule
